// ---- logic/imdu_adder.sv ----
// Purpose: Shared add/subtract datapath of the iterative unit.
// Assumes: Purely combinational; the caller selects the operands.
// Notes:   One adder serves both Booth steps and divide steps.

`timescale 1ns/1ps

module imdu_adder
(
  // Operands.
  input  wire logic [imdu_pkg::ACC_W-1:0] add_a,
  input  wire logic [imdu_pkg::ACC_W-1:0] add_b,
  // High to subtract add_b from add_a.
  input  wire logic                       add_sub,
  // Result, modulo the accumulator width.
  output logic      [imdu_pkg::ACC_W-1:0] add_sum
);

  // ----------------------------------------------------------------------
  // Two's complement add or subtract
  // ----------------------------------------------------------------------

  // Subtraction inverts the second operand and injects a carry.
  assign add_sum = add_a + (add_b ^ {imdu_pkg::ACC_W{add_sub}})
                 + {{(imdu_pkg::ACC_W-1){1'b0}}, add_sub};

endmodule

// ---- logic/imdu_pkg.sv ----
// Purpose: Shared constants and types of the iterative multiply/divide unit.
// Assumes: A 32-bit data path and one operation in flight at a time.
// Notes:   Word, accumulator and counter widths, the last step index and the result reset value live here.

package imdu_pkg;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------

  // Operand and result word width.
  localparam int unsigned WORD_W = 32;
  // Working accumulator width: word plus guard bits for a doubled Booth digit.
  localparam int unsigned ACC_W  = 35;
  // Width of the iteration counter.
  localparam int unsigned CNT_W  = 5;

  // ----------------------------------------------------------------------
  // Timing counts and reset values
  // ----------------------------------------------------------------------

  // Index of the last of the 32 one-bit iterations, for multiply and divide.
  localparam logic [CNT_W-1:0]  STEP_LAST    = 5'h1f;
  // Reset value of every result register.
  localparam logic [WORD_W-1:0] RESULT_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // Operation codes and sequencer states
  // ----------------------------------------------------------------------

  // Operation requested by the integer pipeline.
  typedef enum logic [2:0] {
    OP_PAIR_PRODUCT,
    OP_THREE_OPERAND,
    OP_MULTIPLY_ADD,
    OP_MULTIPLY_SUBTRACT,
    OP_DIVIDE
  } imdu_op_type;

  // States of the single shared multiply/divide sequencer.
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_BOOTH,
    ST_ACC_LOW,
    ST_ACC_HIGH,
    ST_NEG_DIVIDEND,
    ST_DIVIDE_ITER,
    ST_FIX_QUOT,
    ST_FIX_REM,
    ST_WRITE
  } imdu_state_type;

endpackage

// ---- logic/imdu_top.sv ----
// Purpose: Area-saving iterative multiply/divide unit beside the integer pipeline.
// Assumes: Requests come from logic on the same clock; no stall input exists.
// Notes:   One bit per clock; results land in the upper/lower result pair, three-operand results in gpr_result_r.

`timescale 1ns/1ps

module imdu_top
(
  // Clock, reset and freeze.
  input  wire logic                        clk,
  input  wire logic                        rst_b,
  input  wire logic                        clk_en,
  // Operation request from the execute stage.
  input  wire logic                        start_req,
  input  wire imdu_pkg::imdu_op_type       op_code,
  input  wire logic                        op_signed,
  input  wire logic [imdu_pkg::WORD_W-1:0] rs_value,
  input  wire logic [imdu_pkg::WORD_W-1:0] rt_value,
  // Move-to writes into the result pair.
  input  wire logic                        move_to_upper,
  input  wire logic                        move_to_lower,
  input  wire logic [imdu_pkg::WORD_W-1:0] move_to_data,
  // Result pair.
  output logic      [imdu_pkg::WORD_W-1:0] upper_result_reg_r,
  output logic      [imdu_pkg::WORD_W-1:0] lower_result_reg_r,
  // Three-operand result towards the register file.
  output logic      [imdu_pkg::WORD_W-1:0] gpr_result_r,
  output logic                             gpr_write_r,
  // Status towards the integer pipeline.
  output logic                             ready_r,
  output logic                             busy_r,
  output logic                             done_r
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------

  imdu_pkg::imdu_state_type        state_r;      // Sequencer state.
  imdu_pkg::imdu_state_type        state_nxt;    // Next sequencer state.
  imdu_pkg::imdu_state_type        first_state;  // Entry state of a new request.
  imdu_pkg::imdu_op_type           op_r;         // Operation in flight.
  logic                            signed_r;     // Operation is signed.
  logic                            quot_neg_r;   // Quotient must be negated.
  logic                            rem_neg_r;    // Remainder (and dividend) negative.
  logic [imdu_pkg::CNT_W-1:0]      cnt_r;        // Iteration counter.
  logic [imdu_pkg::ACC_W-1:0]      acc_r;        // Upper product / remainder.
  logic [imdu_pkg::WORD_W-1:0]     q_r;          // Multiplier-product / quotient.
  logic                            q_prev_r;     // Booth look-behind bit.
  logic [imdu_pkg::ACC_W-1:0]      mcand_r;      // Multiplicand or divisor.
  logic                            carry_r;      // Carry between accumulate halves.
  logic                            accept;       // Request taken this cycle.
  logic                            last_step;    // Final iteration this cycle.
  logic                            is_acc_op;    // Multiply-add or -subtract.
  logic [imdu_pkg::WORD_W-1:0]     acc_mask;     // Inverts product when subtracting.
  logic [imdu_pkg::ACC_W-1:0]      add_a;        // Shared adder operand A.
  logic [imdu_pkg::ACC_W-1:0]      add_b;        // Shared adder operand B.
  logic                            add_sub;      // Shared adder subtract.
  logic [imdu_pkg::ACC_W-1:0]      add_sum;      // Shared adder result.
  logic [imdu_pkg::ACC_W-1:0]      rem_fix;      // Remainder restored if negative.
  logic [imdu_pkg::WORD_W:0]       acc_low_sum;  // Low half of accumulate, with carry.
  logic [imdu_pkg::WORD_W-1:0]     acc_high_sum; // High half of accumulate.
  logic [1:0]                      booth_pair;   // Current and previous multiplier bit.

  // A request is taken only when the sequencer is free or finishing.
  assign accept     = start_req && ready_r;
  assign last_step  = (cnt_r == imdu_pkg::STEP_LAST);
  assign is_acc_op  = (op_r == imdu_pkg::OP_MULTIPLY_ADD)
                   || (op_r == imdu_pkg::OP_MULTIPLY_SUBTRACT);
  assign acc_mask   = {imdu_pkg::WORD_W{op_r == imdu_pkg::OP_MULTIPLY_SUBTRACT}};
  assign booth_pair = {q_r[0], q_prev_r};
  assign first_state = (op_code == imdu_pkg::OP_DIVIDE) ? imdu_pkg::ST_NEG_DIVIDEND
                                                        : imdu_pkg::ST_BOOTH;

  // ----------------------------------------------------------------------
  // Shared adder and its operand selection
  // ----------------------------------------------------------------------

  // Operand selection for the single adder; idle states add zero.
  always_comb
  begin
    add_a   = acc_r;
    add_b   = '0;
    add_sub = 1'b0;
    case (state_r)
      imdu_pkg::ST_BOOTH:
      begin
        if (last_step && !signed_r)
        begin
          // Unsigned: the top digit folds in the extra zero bit, giving 0, 1 or 2.
          case (booth_pair)
            2'b11:   add_b = {mcand_r[imdu_pkg::ACC_W-2:0], 1'b0};
            2'b10,
            2'b01:   add_b = mcand_r;
            default: add_b = '0;
          endcase
        end
        else
        begin
          // Radix-2 recoding: a 1-to-0 step subtracts, a 0-to-1 step adds.
          case (booth_pair)
            2'b10:
            begin
              add_b   = mcand_r;
              add_sub = 1'b1;
            end
            2'b01:   add_b = mcand_r;
            default: add_b = '0;
          endcase
        end
      end
      imdu_pkg::ST_DIVIDE_ITER:
      begin
        // Shift in the next dividend bit, then subtract or add the divisor.
        add_a   = {acc_r[imdu_pkg::ACC_W-2:0], q_r[imdu_pkg::WORD_W-1]};
        add_b   = mcand_r;
        add_sub = ~acc_r[imdu_pkg::ACC_W-1];
      end
      default:
      begin
        add_a = acc_r;
      end
    endcase
  end

  imdu_adder u_adder
  (
    .add_a   (add_a),
    .add_b   (add_b),
    .add_sub (add_sub),
    .add_sum (add_sum)
  );

  // A negative final remainder gets the divisor back before sign fixing.
  assign rem_fix = add_sum[imdu_pkg::ACC_W-1] ? (add_sum + mcand_r) : add_sum;

  // The two accumulate cycles: low half with carry out, then high half.
  assign acc_low_sum  = {1'b0, lower_result_reg_r} + {1'b0, q_r ^ acc_mask}
                      + {{imdu_pkg::WORD_W{1'b0}}, acc_mask[0]};
  assign acc_high_sum = upper_result_reg_r + (acc_r[imdu_pkg::WORD_W-1:0] ^ acc_mask)
                      + {{(imdu_pkg::WORD_W-1){1'b0}}, carry_r};

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------

  // Next state; there is no stall input, so only the unit's own progress counts.
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      imdu_pkg::ST_IDLE:
        if (accept) state_nxt = first_state;
      imdu_pkg::ST_BOOTH:
        if (last_step) state_nxt = is_acc_op ? imdu_pkg::ST_ACC_LOW
                                             : imdu_pkg::ST_WRITE;
      imdu_pkg::ST_ACC_LOW:
        state_nxt = imdu_pkg::ST_ACC_HIGH;
      imdu_pkg::ST_ACC_HIGH:
        state_nxt = imdu_pkg::ST_WRITE;
      imdu_pkg::ST_NEG_DIVIDEND:
        state_nxt = imdu_pkg::ST_DIVIDE_ITER;
      imdu_pkg::ST_DIVIDE_ITER:
        if (last_step)
        begin
          // Sign-fix cycles that are not needed are skipped outright.
          if (quot_neg_r)     state_nxt = imdu_pkg::ST_FIX_QUOT;
          else if (rem_neg_r) state_nxt = imdu_pkg::ST_FIX_REM;
          else                state_nxt = imdu_pkg::ST_WRITE;
        end
      imdu_pkg::ST_FIX_QUOT:
        state_nxt = rem_neg_r ? imdu_pkg::ST_FIX_REM : imdu_pkg::ST_WRITE;
      imdu_pkg::ST_FIX_REM:
        state_nxt = imdu_pkg::ST_WRITE;
      imdu_pkg::ST_WRITE:
        // A new request may enter while this one writes back.
        state_nxt = accept ? first_state : imdu_pkg::ST_IDLE;
      default:
        state_nxt = imdu_pkg::ST_IDLE;
    endcase
  end

  // State register; only the clock enable can freeze it.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      state_r <= imdu_pkg::ST_IDLE;
    else if (clk_en)
      state_r <= state_nxt;
  end

  // Request attributes, captured once per accepted operation.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      op_r       <= imdu_pkg::OP_PAIR_PRODUCT;
      signed_r   <= 1'b0;
      quot_neg_r <= 1'b0;
      rem_neg_r  <= 1'b0;
    end
    else if (clk_en && accept)
    begin
      op_r       <= op_code;
      signed_r   <= op_signed;
      quot_neg_r <= op_signed && (rs_value[imdu_pkg::WORD_W-1] ^ rt_value[imdu_pkg::WORD_W-1]);
      rem_neg_r  <= op_signed && rs_value[imdu_pkg::WORD_W-1];
    end
  end

  // Iteration counter; it wraps to zero after the last step by itself.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      cnt_r <= '0;
    else if (clk_en)
    begin
      if (accept)
        cnt_r <= '0;
      else if (state_r == imdu_pkg::ST_BOOTH || state_r == imdu_pkg::ST_DIVIDE_ITER)
        cnt_r <= cnt_r + 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Datapath registers
  // ----------------------------------------------------------------------

  // Working registers; a new request loads them even during write-back,
  // which is safe because the result pair samples them on that same edge.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      acc_r    <= '0;
      q_r      <= '0;
      q_prev_r <= 1'b0;
      mcand_r  <= '0;
      carry_r  <= 1'b0;
    end
    else if (clk_en)
    begin
      if (accept)
      begin
        acc_r    <= '0;
        q_prev_r <= 1'b0;
        if (op_code == imdu_pkg::OP_DIVIDE)
        begin
          q_r     <= rs_value;
          mcand_r <= {{3{op_signed & rt_value[imdu_pkg::WORD_W-1]}}, rt_value};
        end
        else
        begin
          q_r     <= rt_value;
          mcand_r <= {{3{op_signed & rs_value[imdu_pkg::WORD_W-1]}}, rs_value};
        end
      end
      else
      begin
        case (state_r)
          imdu_pkg::ST_BOOTH:
          begin
            // Arithmetic shift right of the whole product by one bit.
            acc_r    <= {add_sum[imdu_pkg::ACC_W-1], add_sum[imdu_pkg::ACC_W-1:1]};
            q_r      <= {add_sum[0], q_r[imdu_pkg::WORD_W-1:1]};
            q_prev_r <= q_r[0];
          end
          imdu_pkg::ST_ACC_LOW:
          begin
            q_r     <= acc_low_sum[imdu_pkg::WORD_W-1:0];
            carry_r <= acc_low_sum[imdu_pkg::WORD_W];
          end
          imdu_pkg::ST_ACC_HIGH:
            acc_r <= {3'h0, acc_high_sum};
          imdu_pkg::ST_NEG_DIVIDEND:
          begin
            // Spent even for a positive dividend; the divisor is made positive too.
            if (rem_neg_r) q_r <= -q_r;
            if (mcand_r[imdu_pkg::ACC_W-1]) mcand_r <= -mcand_r;
            acc_r <= '0;
          end
          imdu_pkg::ST_DIVIDE_ITER:
          begin
            acc_r <= last_step ? rem_fix : add_sum;
            q_r   <= {q_r[imdu_pkg::WORD_W-2:0], ~add_sum[imdu_pkg::ACC_W-1]};
          end
          imdu_pkg::ST_FIX_QUOT:
            q_r <= -q_r;
          imdu_pkg::ST_FIX_REM:
            acc_r <= -acc_r;
          default:
            carry_r <= carry_r;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Result registers
  // ----------------------------------------------------------------------

  // Result pair; a move-to on the write-back cycle wins, as it is the younger one.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      upper_result_reg_r <= imdu_pkg::RESULT_RESET;
      lower_result_reg_r <= imdu_pkg::RESULT_RESET;
    end
    else if (clk_en)
    begin
      if (state_r == imdu_pkg::ST_WRITE && op_r != imdu_pkg::OP_THREE_OPERAND)
      begin
        upper_result_reg_r <= acc_r[imdu_pkg::WORD_W-1:0];
        lower_result_reg_r <= q_r;
      end
      if (move_to_upper) upper_result_reg_r <= move_to_data;
      if (move_to_lower) lower_result_reg_r <= move_to_data;
    end
  end

  // Three-operand result goes to the register file port, not the pair.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      gpr_result_r <= imdu_pkg::RESULT_RESET;
      gpr_write_r  <= 1'b0;
    end
    else if (clk_en)
    begin
      gpr_write_r <= (state_r == imdu_pkg::ST_WRITE) && (op_r == imdu_pkg::OP_THREE_OPERAND);
      if (state_r == imdu_pkg::ST_WRITE && op_r == imdu_pkg::OP_THREE_OPERAND)
        gpr_result_r <= q_r;
    end
  end

  // Status flags; busy stays high until the result is really in place.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ready_r <= 1'b1;
      busy_r  <= 1'b0;
      done_r  <= 1'b0;
    end
    else if (clk_en)
    begin
      ready_r <= (state_nxt == imdu_pkg::ST_IDLE) || (state_nxt == imdu_pkg::ST_WRITE);
      busy_r  <= (state_nxt != imdu_pkg::ST_IDLE);
      done_r  <= (state_r == imdu_pkg::ST_WRITE);
    end
  end

endmodule

// ---- sim/imdu_pipe_model.sv ----
// Purpose: Integer pipeline side that issues operations and move-to writes.
// Assumes: Requests change just after a rising edge and hold until taken.
// Notes:   Operands are scrambled once released, as a real pipeline would.

`timescale 1ns/1ps

module imdu_pipe_model
(
  // Clock and status from the unit.
  input  wire logic                        clk,
  input  wire logic                        clk_en,
  input  wire logic                        ready_r,
  input  wire logic                        busy_r,
  // Request and move-to group.
  output logic                             start_req,
  output imdu_pkg::imdu_op_type            op_code,
  output logic                             op_signed,
  output logic      [imdu_pkg::WORD_W-1:0] rs_value,
  output logic      [imdu_pkg::WORD_W-1:0] rt_value,
  output logic                             move_to_upper,
  output logic                             move_to_lower,
  output logic      [imdu_pkg::WORD_W-1:0] move_to_data
);
  // Idle values from time zero.
  initial
  begin
    {start_req, op_signed, move_to_upper, move_to_lower} = 4'h0;
    op_code = imdu_pkg::OP_PAIR_PRODUCT;
    {rs_value, rt_value, move_to_data} = {3{32'h5a5a_a5a5}};
  end

  // Hold the request until an enabled edge sees ready high.
  task automatic issue(input imdu_pkg::imdu_op_type op, input logic sg,
                       input logic [31:0] a, input logic [31:0] b);
    int n;
    @(posedge clk);
    start_req <= 1'b1;
    op_code   <= op;
    op_signed <= sg;
    rs_value  <= a;
    rt_value  <= b;
    for (n = 0; n < 100; n++)
    begin
      @(negedge clk);
      if (ready_r && clk_en) break;
    end
    @(posedge clk);
    start_req <= 1'b0;
    rs_value  <= ~a;
    rt_value  <= ~b;
  endtask

  // Readers of the pair wait here until the unit reports no result pending.
  task automatic wait_idle();
    int n;
    for (n = 0; n < 200; n++)
    begin
      @(negedge clk);
      if (!busy_r) break;
    end
  endtask

  // One-cycle move-to write into the result pair.
  task automatic move_to(input logic up, input logic lo, input logic [31:0] d);
    @(posedge clk);
    move_to_upper <= up;
    move_to_lower <= lo;
    move_to_data  <= d;
    @(posedge clk);
    move_to_upper <= 1'b0;
    move_to_lower <= 1'b0;
    move_to_data  <= ~d;
  endtask
endmodule

// ---- sim/imdu_props.sv ----
// Purpose: Port-level timing checks of the iterative multiply/divide unit.
// Assumes: Sees the top ports only; clk_en low freezes the whole unit.
// Notes:   Helper flops count enabled edges since the last take.

`timescale 1ns/1ps

module imdu_props
(
  // Clock, reset and freeze.
  input wire logic                        clk,
  input wire logic                        rst_b,
  input wire logic                        clk_en,
  // Request group.
  input wire logic                        start_req,
  input wire imdu_pkg::imdu_op_type       op_code,
  input wire logic                        op_signed,
  input wire logic [imdu_pkg::WORD_W-1:0] rs_value,
  input wire logic [imdu_pkg::WORD_W-1:0] rt_value,
  // Move-to group.
  input wire logic                        move_to_upper,
  input wire logic                        move_to_lower,
  input wire logic [imdu_pkg::WORD_W-1:0] move_to_data,
  // Results and status.
  input wire logic [imdu_pkg::WORD_W-1:0] upper_result_reg_r,
  input wire logic [imdu_pkg::WORD_W-1:0] lower_result_reg_r,
  input wire logic                        gpr_write_r,
  input wire logic                        ready_r,
  input wire logic                        busy_r,
  input wire logic                        done_r
);
  logic       pend_r;  // An operation is in flight.
  logic [5:0] cnt_r;   // Enabled edges since the take.
  logic [5:0] lat_r;   // Enabled edges from take to write-back.
  logic       due_r;   // The last enabled edge was a write-back edge.
  logic [5:0] lat_nxt; // Edge count of the request now presented.
  logic       take;    // The request is taken at this edge.
  logic       last;    // This cycle is the write cycle.

  assign take = start_req && ready_r && clk_en;
  assign last = pend_r && (cnt_r + 6'h01 == lat_r);
  // A divide spends one fix cycle when rt is negative, two when only rs is.
  assign lat_nxt = (op_code == imdu_pkg::OP_DIVIDE)
                 ? 6'h22 + {5'h00, op_signed & rt_value[31]}
                   + {4'h0, op_signed & rs_value[31] & ~rt_value[31], 1'b0}
                 : (op_code == imdu_pkg::OP_MULTIPLY_ADD
                    || op_code == imdu_pkg::OP_MULTIPLY_SUBTRACT) ? 6'h23 : 6'h21;

  // Track the operation in flight; a take in the write cycle restarts the count.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pend_r <= 1'b0;
      cnt_r  <= 6'h00;
      lat_r  <= 6'h21;
      due_r  <= 1'b0;
    end
    else if (clk_en)
    begin
      due_r <= last;
      cnt_r <= take ? 6'h00 : cnt_r + 6'h01;
      lat_r <= take ? lat_nxt : lat_r;
      pend_r <= take || (pend_r && !last);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  chk_done_timing: assert property (done_r == due_r)
    else $error("done pulse off its expected cycle");
  chk_busy_span: assert property (busy_r == pend_r)
    else $error("busy flag does not span the operation");
  chk_ready_window: assert property (ready_r == (!pend_r || last))
    else $error("ready flag wrong for the repeat rate");
  chk_move_upper: assert property (clk_en && move_to_upper |=>
    upper_result_reg_r == $past(move_to_data)) else $error("move to upper lost");
  chk_move_lower: assert property (clk_en && move_to_lower |=>
    lower_result_reg_r == $past(move_to_data)) else $error("move to lower lost");
  chk_upper_hold: assert property (!(clk_en && (move_to_upper || last)) |=>
    $stable(upper_result_reg_r)) else $error("upper word changed off write-back");
  chk_lower_hold: assert property (!(clk_en && (move_to_lower || last)) |=>
    $stable(lower_result_reg_r)) else $error("lower word changed off write-back");
  chk_gpr_pulse: assert property (gpr_write_r && clk_en |=> !gpr_write_r)
    else $error("register write pulse too long");

  cov_signed_div: cover property (take && op_code == imdu_pkg::OP_DIVIDE && op_signed
    && rs_value[31] && !rt_value[31]);
  cov_chained: cover property (take && busy_r);
  cov_frozen: cover property (!clk_en && busy_r);
endmodule

bind imdu_top imdu_props i_imdu_props (.clk, .rst_b, .clk_en, .start_req, .op_code,
  .op_signed, .rs_value, .rt_value, .move_to_upper, .move_to_lower, .move_to_data,
  .upper_result_reg_r, .lower_result_reg_r, .gpr_write_r, .ready_r, .busy_r, .done_r);

// ---- sim/iterative_mul_div_unit_test.sv ----
// Purpose: Self-checking bench comparing the unit with a queue-based model.
// Assumes: 20 MHz clock; operands random from a fixed seed.
// Notes:   Latencies count enabled edges, so a freeze does not shift them.

`timescale 1ns/1ps

module iterative_mul_div_unit_test;
  typedef struct {
    logic        three;
    logic [31:0] hi;
    logic [31:0] lo;
    logic [31:0] gpr;
    int          lat;
    int          take;
  } imdu_exp_type;

  logic                  clk, rst_b, clk_en, start_req, op_signed, gpr_write_r;
  logic                  move_to_upper, move_to_lower, ready_r, busy_r, done_r;
  imdu_pkg::imdu_op_type op_code;
  logic [31:0]           rs_value, rt_value, move_to_data, gpr_result_r;
  logic [31:0]           upper_result_reg_r, lower_result_reg_r;
  logic [63:0]           pair;         // Model of the result pair.
  imdu_exp_type          exp_q[$];     // Expected results not yet taken.
  imdu_exp_type          run_q[$];     // Taken operations awaiting done.
  imdu_exp_type          e;
  int                    n_mismatch, checks_done, n_cyc, en_cyc, n_gpr, n_three;
  int                    prev_take, prev_lat, i, seed;
  logic                  done_prev, gpr_prev;

  imdu_top i_imdu_top (.clk, .rst_b, .clk_en, .start_req, .op_code, .op_signed,
    .rs_value, .rt_value, .move_to_upper, .move_to_lower, .move_to_data,
    .upper_result_reg_r, .lower_result_reg_r, .gpr_result_r, .gpr_write_r,
    .ready_r, .busy_r, .done_r);
  imdu_pipe_model i_imdu_pipe_model (.clk, .clk_en, .ready_r, .busy_r, .start_req,
    .op_code, .op_signed, .rs_value, .rt_value, .move_to_upper, .move_to_lower,
    .move_to_data);

  always #25 clk = ~clk;

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("Checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Work out the expected result from the model pair, then issue.
  task automatic run(input imdu_pkg::imdu_op_type op, input logic sg,
                     input logic [31:0] a, input logic [31:0] b);
    logic [63:0]  p;
    imdu_exp_type x;
    p = sg ? {{32{a[31]}}, a} * {{32{b[31]}}, b} : {32'h0, a} * {32'h0, b};
    x.three = (op == imdu_pkg::OP_THREE_OPERAND);
    x.gpr = p[31:0];
    x.lat = 33;
    x.take = 0;
    n_three += x.three;
    case (op)
      imdu_pkg::OP_PAIR_PRODUCT: pair = p;
      imdu_pkg::OP_MULTIPLY_ADD: {pair, x.lat} = {pair + p, 32'd35};
      imdu_pkg::OP_MULTIPLY_SUBTRACT: {pair, x.lat} = {pair - p, 32'd35};
      imdu_pkg::OP_DIVIDE:
      begin
        // Fix cycles: one when rt is negative, two when only rs is.
        x.lat = 34 + ((sg && b[31]) ? 1 : 0) + ((sg && a[31] && !b[31]) ? 2 : 0);
        if (sg)
          pair = {32'($signed(a) % $signed(b)), 32'($signed(a) / $signed(b))};
        else
          pair = {a % b, a / b};
      end
      default: ;
    endcase
    {x.hi, x.lo} = pair;
    exp_q.push_back(x);
    i_imdu_pipe_model.issue(op, sg, a, b);
  endtask

  // Watch takes and completions; settled values are read at the falling edge.
  always @(negedge clk)
  begin
    if (rst_b && start_req && ready_r && clk_en && exp_q.size() > 0)
    begin
      e = exp_q.pop_front();
      if (busy_r)
        check("repeat", 64'(en_cyc + 1 - prev_take), 64'(prev_lat));
      prev_take = en_cyc + 1;
      prev_lat = e.lat;
      e.take = en_cyc + 1;
      run_q.push_back(e);
    end
    if (done_r && !done_prev && run_q.size() > 0)
    begin
      e = run_q.pop_front();
      check("latency", 64'(en_cyc - e.take), 64'(e.lat));
      check("upper", {32'h0, upper_result_reg_r}, {32'h0, e.hi});
      check("lower", {32'h0, lower_result_reg_r}, {32'h0, e.lo});
      if (e.three)
        check("gpr", {32'h0, gpr_result_r}, {32'h0, e.gpr});
    end
    if (gpr_write_r && !gpr_prev)
      n_gpr++;
    done_prev = done_r;
    gpr_prev = gpr_write_r;
    if (clk_en)
      en_cyc++;
  end

  // Cut a hang short; the run needs about 1700 cycles.
  always @(posedge clk)
  begin
    n_cyc++;
    if (n_cyc > 6000)
    begin
      n_mismatch++;
      test_done();
    end
  end

  logic [31:0]           a, b;
  logic                  sg;
  logic [2:0]            op;

  initial
  begin
    {n_mismatch, checks_done, n_cyc, en_cyc, n_gpr, n_three, prev_take, prev_lat} = '0;
    {done_prev, gpr_prev, clk, rst_b, clk_en} = 5'h01;
    pair = 64'h0;
    seed = 32'h97a44322;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    for (i = 0; i < 48; i++)
    begin
      a = $random(seed);
      b = $random(seed);
      sg = 1'($random(seed));
      op = 3'(($random(seed) & 32'hffff) % 5);
      // Every operation both ways first, then all four divide sign pairs.
      if (i < 10)
        {op, sg} = {3'(i % 5), 1'(i >= 5)};
      if (i >= 10 && i < 14)
        {op, sg, a[31], b[31]} = {imdu_pkg::OP_DIVIDE, 1'b1, 1'(i), 1'(i >> 1)};
      if (i % 8 == 0 && i >= 16)
        op = imdu_pkg::OP_MULTIPLY_ADD;
      // Zero divisors are replaced last.
      if (b == 32'h0 || &b)
        b = 32'h7;
      run(imdu_pkg::imdu_op_type'(op), sg, a, b);
      // Freeze mid-operation; the count of enabled edges must not change.
      if (i == 20)
      begin
        repeat (8) @(posedge clk);
        clk_en <= 1'b0;
        repeat (5) @(posedge clk);
        clk_en <= 1'b1;
      end
      // Every fourth operation is followed by a move-to while idle.
      if (i % 4 == 3)
      begin
        i_imdu_pipe_model.wait_idle();
        a = $random(seed);
        i_imdu_pipe_model.move_to(1'(i >> 2), !i[2] || i[3], a);
        if (i[2])
          pair[63:32] = a;
        if (!i[2] || i[3])
          pair[31:0] = a;
        @(negedge clk);
        check("pair after move", {upper_result_reg_r, lower_result_reg_r}, pair);
      end
    end
    i_imdu_pipe_model.wait_idle();
    @(negedge clk);
    check("gpr writes", 64'(n_gpr), 64'(n_three));
    test_done();
  end
endmodule
